// ### rtl/disk_ctrl_status_error_regs.sv
`timescale 1ns/100ps
// Contract
// - State bit 7 reads 0 while controller busy, 1 when ready.
// - State bit 6 reads 1 when drive ready, else 0.
// - State bit 5 set on drive write fault; stays set until the next command starts.
// - State bit 4 reads 1 once heads settled over a track.
// - State bit 3 reads 1 when drive ready to move data.
// - State bit 2 set when correctable error was corrected.
// - State bit 1 reads 1 while index mark is sensed.
// - State bit 0 set when previous command ended in error.
// - Cause bit 7 set on bad block mark during command.
// - Cause bit 6 set on uncorrectable data error.
// - Cause bit 4 set when sector ID field not found.
// - Cause bit 2 set on illegal command or drive status error.
// - Cause bit 1 set when recalibrate misses track 0, else cleared.
// - Cylinders 0..804, heads 0..3, sectors from 1, 512-byte sectors.
module disk_ctrl_status_error_regs
	import disk_status_pkg::*;
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Drive status pins
	input wire drive_lines_t drive_lines,
	// Command engine side
	input wire logic cmd_start,
	input wire logic cmd_done,
	input wire logic recal_cmd,
	input wire logic recal_track0_found,
	input wire disk_addr_t cmd_addr,
	input wire fault_events_t fault_events,
	// Interrupt
	output logic irq
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		drive_lines_t s1;
		drive_lines_t s2;
		drive_lines_t s3;
		drive_lines_t lines;
		ctrl_state_t fsm;
		logic write_fault;
		logic corrected;
		logic error;
		logic [7:0] cause;
		logic [irq_bits-1:0] irq_status;
		logic [irq_bits-1:0] irq_mask;
		disk_addr_t addr;
		logic [31:0] rdata;
	} regs_t;

	regs_t r_q;
	regs_t r_d;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// Shared address decode
	function automatic logic addr_is(input logic [7:0] a, input logic [7:0] off);
		addr_is = (a == off);
	endfunction : addr_is

	// Address outside the geometry counts as an aborted command
	function automatic logic addr_ok(input disk_addr_t a);
		addr_ok = (a.cylinder <= max_cylinder) && (a.head <= max_head) &&
			(a.sector >= first_sector);
	endfunction : addr_ok

	// ----------------------------------------
	// Address map
	// ----------------------------------------
	// Six aligned words; anything else answers with a bus error
	function automatic logic is_mapped(input logic [7:0] a);
		is_mapped = 1'b0;
		if (addr_is(a, off_state) || addr_is(a, off_cause)) begin
			is_mapped = 1'b1;
		end
		if (addr_is(a, off_irq_status) || addr_is(a, off_irq_mask)) begin
			is_mapped = 1'b1;
		end
		if (addr_is(a, off_geometry) || addr_is(a, off_address)) begin
			is_mapped = 1'b1;
		end
	endfunction : is_mapped

	// ----------------------------------------
	// Pin filter
	// ----------------------------------------
	// Only a level seen in both late stages passes; one odd sample is dropped
	function automatic drive_lines_t settle(
		input drive_lines_t held,
		input drive_lines_t late,
		input drive_lines_t last
	);
		settle = held;
		if (late == last) begin
			settle = last;
		end
	endfunction : settle

	// ----------------------------------------
	// State byte packing
	// ----------------------------------------
	// Bit 7 is a ready flag: busy reads as zero, ready as one
	function automatic logic [7:0] state_pack(
		input ctrl_state_t fsm,
		input drive_lines_t lines,
		input logic write_fault,
		input logic corrected,
		input logic error
	);
		state_pack = reset_byte;
		state_pack[st_busy_n] = (fsm == st_idle);
		state_pack[st_drive_ready] = lines.drive_ready;
		state_pack[st_write_fault] = write_fault;
		state_pack[st_seek_settled] = lines.seek_settled;
		state_pack[st_transfer_req] = lines.transfer_req;
		state_pack[st_corrected] = corrected;
		state_pack[st_index] = lines.index_pulse;
		state_pack[st_error] = error;
	endfunction : state_pack

	// ----------------------------------------
	// Fault cause collection
	// ----------------------------------------
	// Set terms only; the caller ors them into the held byte
	function automatic logic [7:0] cause_events(
		input fault_events_t f,
		input logic write_fault
	);
		cause_events = reset_byte;
		if (f.bad_block) begin
			cause_events[fc_bad_block] = 1'b1;
		end
		if (f.uncorrectable) begin
			cause_events[fc_uncorrectable] = 1'b1;
		end
		if (f.id_missing) begin
			cause_events[fc_id_missing] = 1'b1;
		end
		// A write fault during a command is a drive status error
		if (f.aborted || write_fault) begin
			cause_events[fc_aborted] = 1'b1;
		end
		// Unused positions never leave this function set
		cause_events = cause_events & fc_used_mask;
	endfunction : cause_events

	// ----------------------------------------
	// Recalibrate outcome
	// ----------------------------------------
	// A miss beats a find in the same cycle; other commands leave the bit
	function automatic logic recal_bit(
		input logic held,
		input logic recal,
		input logic missing,
		input logic found
	);
		recal_bit = held;
		if (recal && missing) begin
			recal_bit = 1'b1;
		end else if (recal && found) begin
			recal_bit = 1'b0;
		end
	endfunction : recal_bit

	// ----------------------------------------
	// Interrupt status
	// ----------------------------------------
	// Write-one-to-clear; an event in the same cycle wins over the clear
	function automatic logic [irq_bits-1:0] irq_next(
		input logic [irq_bits-1:0] status,
		input logic clear_en,
		input logic [irq_bits-1:0] clear_bits,
		input logic [irq_bits-1:0] events
	);
		irq_next = status;
		if (clear_en) begin
			irq_next = status & ~clear_bits;
		end
		irq_next = irq_next | events;
	endfunction : irq_next

	// ----------------------------------------
	// Geometry word
	// ----------------------------------------
	function automatic logic [31:0] geometry_word();
		geometry_word = {sector_bytes, 3'h0, first_sector, max_head, 2'h0, max_cylinder};
	endfunction : geometry_word

	// ----------------------------------------
	// Read mux
	// ----------------------------------------
	// Unmapped words read zero; the bus error flags them separately
	function automatic logic [31:0] read_word(
		input logic [7:0] a,
		input logic [7:0] state,
		input logic [7:0] cause,
		input logic [irq_bits-1:0] status,
		input logic [irq_bits-1:0] mask,
		input disk_addr_t addr
	);
		read_word = '0;
		if (addr_is(a, off_state)) begin
			read_word[7:0] = state;
		end
		if (addr_is(a, off_cause)) begin
			read_word[7:0] = cause & fc_used_mask;
		end
		if (addr_is(a, off_irq_status)) begin
			read_word[irq_bits-1:0] = status;
		end
		if (addr_is(a, off_irq_mask)) begin
			read_word[irq_bits-1:0] = mask;
		end
		if (addr_is(a, off_geometry)) begin
			read_word = geometry_word();
		end
		if (addr_is(a, off_address)) begin
			read_word = {15'h0, addr};
		end
	endfunction : read_word

	// ----------------------------------------
	// Bus decode
	// ----------------------------------------
	logic wr_en;
	logic rd_en;
	logic mapped;
	logic [7:0] state_byte;
	logic [irq_bits-1:0] ev;

	assign wr_en = psel && penable && pwrite;
	assign rd_en = psel && !penable && !pwrite;
	assign mapped = is_mapped(paddr);

	// ----------------------------------------
	// State byte
	// ----------------------------------------
	always_comb begin
		state_byte = state_pack(r_q.fsm, r_q.lines, r_q.write_fault, r_q.corrected, r_q.error);
	end

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		r_d = r_q;
		ev = '0;
		// Three-stage sampling; change taken once stages two and three agree
		r_d.s1 = drive_lines;
		r_d.s2 = r_q.s1;
		r_d.s3 = r_q.s2;
		r_d.lines = settle(r_q.lines, r_q.s2, r_q.s3);
		if (r_q.lines.write_fault) begin
			r_d.write_fault = 1'b1;
		end
		unique case (r_q.fsm)
			st_idle: begin
				if (cmd_start) begin
					r_d.fsm = st_busy;
					// Address kept so software reads what the command was given
					r_d.addr = cmd_addr;
					r_d.cause = reset_byte;
					r_d.error = 1'b0;
					r_d.corrected = 1'b0;
					r_d.write_fault = r_q.lines.write_fault;
					if (!addr_ok(cmd_addr)) begin
						r_d.cause[fc_aborted] = 1'b1;
						r_d.error = 1'b1;
						r_d.fsm = st_idle;
						ev[irq_addr_bad] = 1'b1;
						ev[irq_error] = 1'b1;
					end
				end
			end
			st_busy: begin
				if (fault_events.corrected) begin
					r_d.corrected = 1'b1;
				end
				// Cause bits accumulate over the whole command; bit 1 follows the recalibrate outcome
				r_d.cause = r_q.cause | cause_events(fault_events, r_q.lines.write_fault);
				r_d.cause[fc_recal_missing] = recal_bit(r_q.cause[fc_recal_missing], recal_cmd,
					fault_events.recal_missing, recal_track0_found);
				if (cmd_done) begin
					r_d.fsm = st_idle;
					r_d.error = |(r_d.cause & fc_used_mask);
					ev[irq_done] = 1'b1;
					ev[irq_error] = |(r_d.cause & fc_used_mask);
				end
			end
			default: begin
				r_d.fsm = st_idle;
			end
		endcase
		r_d.cause = r_d.cause & fc_used_mask;
		// Write-one-to-clear; a new event in the same cycle wins
		r_d.irq_status = irq_next(r_q.irq_status, wr_en && addr_is(paddr, off_irq_status),
			pwdata[irq_bits-1:0], ev);
		if (wr_en && addr_is(paddr, off_irq_mask)) begin
			r_d.irq_mask = pwdata[irq_bits-1:0];
		end
		// Read data captured in setup, held through access
		if (rd_en) begin
			r_d.rdata = read_word(paddr, state_byte, r_q.cause, r_q.irq_status, r_q.irq_mask,
				r_q.addr);
		end
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r_q <= '0;
			r_q.fsm <= st_idle;
		end else begin
			r_q <= r_d;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	// Zero-wait slave; writes to read-only words are dropped quietly
	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped;
	assign prdata = r_q.rdata;
	assign irq = |(r_q.irq_status & r_q.irq_mask);

endmodule : disk_ctrl_status_error_regs

// ### rtl/disk_status_pkg.sv
package disk_status_pkg;

	// ----------------------------------------
	// Register offsets (byte addresses)
	// ----------------------------------------
	localparam logic [7:0] off_state = 8'h00;
	localparam logic [7:0] off_cause = 8'h04;
	localparam logic [7:0] off_irq_status = 8'h08;
	localparam logic [7:0] off_irq_mask = 8'h0c;
	localparam logic [7:0] off_geometry = 8'h10;
	localparam logic [7:0] off_address = 8'h14;

	// ----------------------------------------
	// Controller state byte fields
	// ----------------------------------------
	localparam int st_busy_n = 7;
	localparam int st_drive_ready = 6;
	localparam int st_write_fault = 5;
	localparam int st_seek_settled = 4;
	localparam int st_transfer_req = 3;
	localparam int st_corrected = 2;
	localparam int st_index = 1;
	localparam int st_error = 0;

	// ----------------------------------------
	// Fault cause byte fields
	// ----------------------------------------
	localparam int fc_bad_block = 7;
	localparam int fc_uncorrectable = 6;
	localparam int fc_id_missing = 4;
	localparam int fc_aborted = 2;
	localparam int fc_recal_missing = 1;
	localparam logic [7:0] fc_used_mask = 8'hd6;

	// ----------------------------------------
	// Geometry limits
	// ----------------------------------------
	localparam logic [9:0] max_cylinder = 10'h324;
	localparam logic [1:0] max_head = 2'h3;
	localparam logic [4:0] first_sector = 5'h01;
	localparam logic [9:0] sector_bytes = 10'h200;

	// ----------------------------------------
	// Interrupt status bits
	// ----------------------------------------
	localparam int irq_done = 0;
	localparam int irq_error = 1;
	localparam int irq_addr_bad = 2;
	localparam int irq_bits = 3;

	localparam logic [7:0] reset_byte = 8'h00;

	typedef struct packed {
		logic drive_ready;
		logic write_fault;
		logic seek_settled;
		logic transfer_req;
		logic index_pulse;
	} drive_lines_t;

	typedef struct packed {
		logic corrected;
		logic bad_block;
		logic uncorrectable;
		logic id_missing;
		logic aborted;
		logic recal_missing;
	} fault_events_t;

	typedef struct packed {
		logic [9:0] cylinder;
		logic [1:0] head;
		logic [4:0] sector;
	} disk_addr_t;

	typedef enum logic [1:0] {
		st_idle = 2'b01,
		st_busy = 2'b10
	} ctrl_state_t;

endpackage : disk_status_pkg

// ### verification/disk_host_model.sv
`timescale 1ns/100ps
module disk_host_model (
	// Register bytes
	input wire logic [7:0] state_byte,
	input wire logic [7:0] cause_byte,
	// Report word
	output logic [15:0] report
);
	// ----
	// Packing: state byte leads so a hex dump reads in fault order
	// ----
	assign report = {state_byte, cause_byte};
endmodule : disk_host_model

// ### verification/disk_ctrl_assertions.sv
`timescale 1ns/100ps
module disk_ctrl_chk
	import disk_status_pkg::*;
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Bus and pins
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] prdata,
	input wire drive_lines_t drive_lines
);
	// ----
	// Eight stable cycles cover the pin synchroniser latency
	// ----
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic rs;
	logic ra;
	assign rs = psel && !penable && !pwrite && paddr == off_state;
	assign ra = psel && penable && !pwrite;
	property p_rdy_hi; drive_lines.drive_ready [*8] ##1 rs |=> prdata[st_drive_ready]; endproperty
	a_rdy_hi: assert property (p_rdy_hi) else $error("drive ready bit low");
	property p_rdy_lo; (!drive_lines.drive_ready) [*8] ##1 rs |=> !prdata[6]; endproperty
	a_rdy_lo: assert property (p_rdy_lo) else $error("drive ready bit high");
	property p_settled; drive_lines.seek_settled [*8] ##1 rs |=> prdata[4]; endproperty
	a_settled: assert property (p_settled) else $error("settled bit low");
	property p_xfer; drive_lines.transfer_req [*8] ##1 rs |=> prdata[st_transfer_req]; endproperty
	a_xfer: assert property (p_xfer) else $error("transfer bit low");
	property p_index; (!drive_lines.index_pulse) [*8] ##1 rs |=> !prdata[1]; endproperty
	a_index: assert property (p_index) else $error("index bit high");
	property p_unused; ra && paddr == off_cause |-> (prdata[7:0] & ~fc_used_mask) == 8'h00; endproperty
	a_unused: assert property (p_unused) else $error("unused cause bit set");
	property p_geo_lo; ra && paddr == off_geometry |-> prdata[13:0] == 14'h3324; endproperty
	a_geo_lo: assert property (p_geo_lo) else $error("cylinder or head limit wrong");
	property p_geo_hi; ra && paddr == off_geometry |-> prdata[31:14] == 18'h20001; endproperty
	a_geo_hi: assert property (p_geo_hi) else $error("sector limit wrong");
endmodule : disk_ctrl_chk
bind disk_ctrl_status_error_regs disk_ctrl_chk i_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .drive_lines(drive_lines));

// ### verification/disk_ctrl_status_error_regs_test.sv
`timescale 1ns/100ps
module disk_ctrl_status_error_regs_test
	import disk_status_pkg::*;
;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	drive_lines_t drive_lines = '0;
	logic cmd_start = 1'b0;
	logic cmd_done = 1'b0;
	logic recal_cmd = 1'b0;
	logic recal_found = 1'b0;
	disk_addr_t cmd_addr = '0;
	fault_events_t fault_events = '0;
	logic irq;
	logic [31:0] rdata;
	logic perr;
	logic [7:0] state_b = 8'h00;
	logic [7:0] cause_b = 8'h00;
	logic [15:0] report;
	int fails = 0;
	int total_checks = 0;
	always #2.5 pclk = ~pclk;
	disk_ctrl_status_error_regs i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .drive_lines(drive_lines), .cmd_start(cmd_start),
		.cmd_done(cmd_done), .recal_cmd(recal_cmd), .recal_track0_found(recal_found),
		.cmd_addr(cmd_addr), .fault_events(fault_events), .irq(irq));
	disk_host_model i_host (.state_byte(state_b), .cause_byte(cause_b), .report(report));
	// ----
	// Bus tasks: idle cycle after each transfer keeps drives single per step
	// ----
	task automatic stop_test;
		if (fails == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : stop_test
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
			fails++;
		end
	endtask : check
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			fails++;
			stop_test();
		end
		rdata = prdata;
		perr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		check(rdata, exp);
	endtask : rd
	task automatic step(input logic s, input logic d, input fault_events_t f);
		cmd_start <= s;
		cmd_done <= d;
		fault_events <= f;
		@(posedge pclk);
		cmd_start <= 1'b0;
		cmd_done <= 1'b0;
		fault_events <= '0;
		@(posedge pclk);
	endtask : step
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		repeat (10) @(posedge pclk);
		rd(off_state, 32'h80);
		rd(off_geometry, {10'h200, 3'h0, 5'h01, 2'h3, 2'h0, 10'h324});
		apb(1'b1, off_irq_mask, 32'h2);
		drive_lines <= 5'b10111;
		repeat (10) @(posedge pclk);
		rd(off_state, 32'hda);
		cmd_addr <= {10'h324, 2'h3, 5'h01};
		step(1'b1, 1'b0, '0);
		rd(off_state, 32'h5a);
		step(1'b0, 1'b0, 6'h3c);
		step(1'b0, 1'b1, '0);
		rd(off_state, 32'hdf);
		state_b = rdata[7:0];
		rd(off_cause, 32'hd0);
		cause_b = rdata[7:0];
		@(posedge pclk);
		check({16'h0, report}, 32'hdfd0);
		check({31'h0, irq}, 32'h1);
		apb(1'b1, off_cause, 32'hff);
		rd(off_cause, 32'hd0);
		apb(1'b1, off_irq_status, 32'h7);
		check({31'h0, irq}, 32'h0);
		cmd_addr <= {10'h325, 2'h0, 5'h01};
		step(1'b1, 1'b0, '0);
		rd(off_cause, 32'h04);
		check({31'h0, irq}, 32'h1);
		cmd_addr <= {10'h000, 2'h0, 5'h01};
		recal_cmd <= 1'b1;
		step(1'b1, 1'b0, '0);
		step(1'b0, 1'b0, 6'h01);
		step(1'b0, 1'b1, '0);
		rd(off_cause, 32'h02);
		step(1'b1, 1'b0, '0);
		step(1'b0, 1'b0, 6'h01);
		recal_found <= 1'b1;
		@(posedge pclk);
		recal_found <= 1'b0;
		step(1'b0, 1'b1, '0);
		rd(off_cause, 32'h00);
		recal_cmd <= 1'b0;
		drive_lines <= 5'b11111;
		repeat (10) @(posedge pclk);
		step(1'b1, 1'b0, '0);
		rd(off_state, 32'h7a);
		step(1'b0, 1'b1, '0);
		rd(off_state, 32'hfb);
		rd(off_cause, 32'h04);
		rd(off_address, 32'h1);
		rd(off_irq_status, 32'h7);
		apb(1'b0, 8'h20, 32'h0);
		check({31'h0, perr}, 32'h1);
		stop_test();
	end
endmodule : disk_ctrl_status_error_regs_test
